//--- rtl/vsm_pkg.sv
`default_nettype none
// shared constants of the valve stroke monitor
package vsm_pkg;
    // clock and timer resolution
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_PERIOD_NS = 1000000; // one timer tick is 1 ms
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [31:0] MS_PER_S = 32'h0000_03E8;

    // register bus widths
    localparam int AW = 6;
    localparam int DW = 32;

    // register offsets (register index on the plain port)
    localparam logic [AW-1:0] ADDR_COIL_MODE = 6'h19;
    localparam logic [AW-1:0] ADDR_DRIVE_MODE = 6'h1A;
    localparam logic [AW-1:0] ADDR_STROKE_COUNT = 6'h1B;
    localparam logic [AW-1:0] ADDR_COUNT_CLEAR = 6'h1C;
    localparam logic [AW-1:0] ADDR_RECOVERY = 6'h1D;
    localparam logic [AW-1:0] ADDR_ALARM_CLEAR = 6'h1E;
    localparam logic [AW-1:0] ADDR_LAST_STROKE = 6'h1F;
    localparam logic [AW-1:0] ADDR_STROKE_LIMIT = 6'h20;
    localparam logic [AW-1:0] ADDR_SHUT_STATE = 6'h21;
    localparam logic [AW-1:0] ADDR_TRAVEL_STATE = 6'h22;
    localparam logic [AW-1:0] ADDR_TIMEOUT_STATE = 6'h23;
    localparam logic [AW-1:0] ADDR_EXT_ALARM = 6'h24;
    localparam logic [AW-1:0] ADDR_ACTION_TIME = 6'h25;

    // setting encodings
    localparam logic [7:0] COIL_SINGLE = 8'h01;
    localparam logic [7:0] COIL_DUAL = 8'h02;
    localparam logic [7:0] COIL_READBACK = 8'h03;
    localparam logic [7:0] DRIVE_PULSE = 8'h01;
    localparam logic [7:0] DRIVE_HOLD = 8'h02;
    localparam logic [7:0] RECOV_ACT = 8'h01;
    localparam logic [7:0] RECOV_WAIT = 8'h02;

    // reset values
    localparam logic [7:0] LIMIT_S_DEF = 8'h0A; // stroke limit, seconds
    localparam logic [7:0] RECOV_DEF = 8'h01;

    // synchronised pin positions
    localparam int PIN_W = 3;
    localparam int PIN_SHUT = 0;
    localparam int PIN_TRAVEL = 1;
    localparam int PIN_EXT = 2;

    // stroke sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MOVE = 3'b010,
        ST_HALT = 3'b100
    } vsm_stroke_e;
endpackage : vsm_pkg
`default_nettype wire

//--- rtl/vsm_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// carries the timer tick and the synchronised pins to the core
interface vsm_link_if;
    logic tick;
    logic [vsm_pkg::PIN_W-1:0] pins_s;
    modport tick_src (output tick);
    modport sync_src (output pins_s);
    modport core (input tick, input pins_s);
endinterface : vsm_link_if
`default_nettype wire

//--- rtl/vsm_tick.sv
`timescale 1ns/10ps
`default_nettype none
// divides the clock down to a one-cycle tick every DIV cycles
module vsm_tick #(
    parameter int unsigned DIV = vsm_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    vsm_link_if.tick_src lk
);
    localparam int CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } vsm_tick_s;

    vsm_tick_s r;
    vsm_tick_s n;

    // count up and wrap, pulsing on the wrap
    always_comb
    begin
        n = r;
        n.tick = (r.cnt == LAST);
        n.cnt = (r.cnt == LAST) ? '0 : r.cnt + CW'(1);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            r <= '0;
        else
            r <= n;
    end

    assign lk.tick = r.tick;
endmodule : vsm_tick
`default_nettype wire

//--- rtl/vsm_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for the contact pins
module vsm_sync (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [vsm_pkg::PIN_W-1:0] pins_async,
    vsm_link_if.sync_src lk
);
    typedef struct packed {
        logic [vsm_pkg::PIN_W-1:0] s1;
        logic [vsm_pkg::PIN_W-1:0] s2;
    } vsm_sync_s;

    vsm_sync_s r;
    vsm_sync_s n;

    // first stage feeds only the second stage
    always_comb
    begin
        n.s1 = pins_async;
        n.s2 = r.s1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            r <= '0;
        else
            r <= n;
    end

    assign lk.pins_s = r.s2;
endmodule : vsm_sync
`default_nettype wire

//--- rtl/vsm_valve_stroke_monitor.sv
// Notes on behaviour
// - stroke counter counts every open-to-closed and closed-to-open move
// - writing the counter-reset setting clears the stroke counter to zero
// - each commanded stroke is timed against the limit, default 10 s; overrun alarms
// - dual coil with pulsed drive energizes the selected coil for one limit period
// - drive setting chooses coil off or held after the limit; dual coil only
// - recovery 1 acts regardless of input change; 2 waits for a new change
// - writing the timeout-reset setting clears the latched stroke-timeout
// - duration of the last completed stroke is captured and readable
// - running time since the latest stroke start, command or retry, is kept and readable
// - coil configuration selects single-coil or dual-coil operation
// - readback mode only on single-coil units; returns limit state to output one
// - first input channel carries the stroke-timeout state
// - dry contact is sampled, readable as external alarm, and on input channel two
// - coil configuration and drive setting reset to factory-fixed defaults
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module vsm_valve_stroke_monitor #(
    parameter int unsigned TICK_CYCLES = vsm_pkg::TICK_CYCLES,
    parameter logic [7:0] DEF_COIL_MODE = vsm_pkg::COIL_DUAL,
    parameter logic [7:0] DEF_DRIVE_MODE = vsm_pkg::DRIVE_HOLD
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [vsm_pkg::AW-1:0] reg_addr,
    input wire logic [vsm_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [vsm_pkg::DW-1:0] reg_rdata,
    input wire logic stroke_cmd_open,
    input wire logic shut_position_contact,
    input wire logic travel_position_contact,
    input wire logic ext_alarm_contact,
    output logic coil_open_drive,
    output logic coil_close_drive,
    output logic first_output_readback,
    output logic first_input_channel,
    output logic second_input_channel
);
    ////////////////////////////////////////////////////////////////////////////
    // state

    // all core state in one struct; the copy n is registered whole
    // on every edge, so no field can miss its update
    typedef struct packed {
        // sequencer and command tracking
        vsm_pkg::vsm_stroke_e st;
        logic booted;
        logic cmd_q;
        logic pulse_on;
        logic alarm;
        logic ext;
        // last end position seen, reference for counting
        logic end_known;
        logic end_open;
        // host settings
        logic [7:0] coil_mode;
        logic [7:0] drive_mode;
        logic [7:0] recov;
        logic [7:0] limit_s;
        // stroke counter and millisecond timers
        logic [31:0] odo;
        logic [31:0] trans_ms;
        logic [31:0] action_ms;
        // registered outputs
        logic [vsm_pkg::DW-1:0] rdata;
        logic coil_open;
        logic coil_close;
        logic readback;
        logic in_ch1;
        logic in_ch2;
    } vsm_core_s;

    // reset image, configuration taken from the factory defaults
    localparam vsm_core_s RST = '{
        st: vsm_pkg::ST_IDLE,
        coil_mode: DEF_COIL_MODE,
        drive_mode: DEF_DRIVE_MODE,
        recov: vsm_pkg::RECOV_DEF,
        limit_s: vsm_pkg::LIMIT_S_DEF,
        // counters, timers and the alarm latch start cleared
        default: '0
    };

    vsm_core_s r;
    vsm_core_s n;
    vsm_link_if lk ();

    ////////////////////////////////////////////////////////////////////////////
    // millisecond tick and pin synchronisers

    // one-cycle tick per millisecond paces every timer
    vsm_tick #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .arst_n(arst_n),
        .lk(lk.tick_src)
    );

    // contacts are asynchronous pins: two flops before any logic
    // reads them, so a bouncing switch cannot split a decision
    vsm_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pins_async({ext_alarm_contact, travel_position_contact, shut_position_contact}),
        .lk(lk.sync_src)
    );

    ////////////////////////////////////////////////////////////////////////////
    // helper terms

    // synchronised contacts, limit in ms and host write decode
    logic shut_s;
    logic travel_s;
    logic [31:0] limit_ms;
    logic timed_out;
    logic wr_hit;
    logic [7:0] wbyte;

    // contact levels, stroke limit in ms and write decode
    assign shut_s = lk.pins_s[vsm_pkg::PIN_SHUT];
    assign travel_s = lk.pins_s[vsm_pkg::PIN_TRAVEL];
    assign limit_ms = 32'(r.limit_s) * vsm_pkg::MS_PER_S;
    assign timed_out = (r.action_ms >= limit_ms);
    // a read beside a write leaves the write undone
    assign wr_hit = reg_wr && !reg_rd;
    assign wbyte = reg_wdata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb
    begin
        // scratch terms, all given a value at the top
        logic start;
        logic go;
        logic at_target;
        logic pos_open;
        logic pos_shut;
        logic dual;
        logic energ;
        start = 1'b0;
        go = 1'b0;
        at_target = 1'b0;
        pos_open = 1'b0;
        pos_shut = 1'b0;
        dual = 1'b0;
        energ = 1'b0;
        n = r;
        n.rdata = '0;

        // a stroke starts on a command change, or at start-up when acting regardless
        start = (stroke_cmd_open != r.cmd_q)
            || (!r.booted && r.recov == vsm_pkg::RECOV_ACT);
        // the start-up decision is taken once only
        n.booted = 1'b1;
        n.cmd_q = stroke_cmd_open;
        // completion is judged on the end the last command asked for
        at_target = r.cmd_q ? travel_s : shut_s;

        // time since the latest stroke start, saturating
        // holds at all ones instead of wrapping to zero
        if (lk.tick && r.action_ms != '1)
            n.action_ms = r.action_ms + 32'h0000_0001;

        // pulse window lasts exactly one stroke limit period
        // only felt in dual coil with pulsed drive
        if (r.pulse_on && timed_out)
            n.pulse_on = 1'b0;

        // host clears come first so that a same-cycle event wins
        // a timeout or count in that cycle sets it again below
        if (wr_hit && reg_addr == vsm_pkg::ADDR_ALARM_CLEAR && wbyte != 8'h00)
            n.alarm = 1'b0;
        if (wr_hit && reg_addr == vsm_pkg::ADDR_COUNT_CLEAR && wbyte != 8'h00)
            n.odo = '0;

        // stroke sequencer
        case (r.st)
            // idle: wait for a command change
            vsm_pkg::ST_IDLE:
            begin
                go = start;
            end
            // moving: a new command wins over completion and timeout
            vsm_pkg::ST_MOVE:
            begin
                if (start)
                    go = 1'b1;
                else if (at_target)
                begin
                    n.trans_ms = r.action_ms;
                    n.st = vsm_pkg::ST_IDLE;
                end
                else if (timed_out)
                begin
                    n.alarm = 1'b1;
                    if (r.recov == vsm_pkg::RECOV_ACT)
                        go = 1'b1;
                    else
                        n.st = vsm_pkg::ST_HALT;
                end
            end
            // halted after a timeout: dual coils off until a new command
            vsm_pkg::ST_HALT:
            begin
                go = start;
            end
            // unreachable codes fall back to idle
            default:
            begin
                n.st = vsm_pkg::ST_IDLE;
            end
        endcase

        // (re)start a stroke: timer from zero, fresh pulse window
        // a restart during a stroke drops the old stroke untimed
        if (go)
        begin
            n.st = vsm_pkg::ST_MOVE;
            n.action_ms = '0;
            n.pulse_on = 1'b1;
        end

        // end positions and stroke counting
        // both contacts made, or neither, is mid travel: no count
        // the first end seen after reset only sets the reference
        pos_open = travel_s && !shut_s;
        pos_shut = shut_s && !travel_s;
        if (pos_open && !(r.end_known && r.end_open))
        begin
            if (r.end_known)
                n.odo = n.odo + 32'h0000_0001;
            n.end_known = 1'b1;
            n.end_open = 1'b1;
        end
        else if (pos_shut && !(r.end_known && !r.end_open))
        begin
            if (r.end_known)
                n.odo = n.odo + 32'h0000_0001;
            n.end_known = 1'b1;
            n.end_open = 1'b0;
        end

        // configuration writes; out-of-range values are ignored
        if (wr_hit)
        begin
            case (reg_addr)
                // readback is refused while dual coil is selected
                vsm_pkg::ADDR_COIL_MODE:
                begin
                    if (wbyte == vsm_pkg::COIL_SINGLE || wbyte == vsm_pkg::COIL_DUAL)
                        n.coil_mode = wbyte;
                    else if (wbyte == vsm_pkg::COIL_READBACK
                        && r.coil_mode != vsm_pkg::COIL_DUAL)
                        n.coil_mode = wbyte;
                end
                vsm_pkg::ADDR_DRIVE_MODE:
                begin
                    if (wbyte == vsm_pkg::DRIVE_PULSE || wbyte == vsm_pkg::DRIVE_HOLD)
                        n.drive_mode = wbyte;
                end
                vsm_pkg::ADDR_RECOVERY:
                begin
                    if (wbyte == vsm_pkg::RECOV_ACT || wbyte == vsm_pkg::RECOV_WAIT)
                        n.recov = wbyte;
                end
                // a zero limit would time out every stroke at once
                vsm_pkg::ADDR_STROKE_LIMIT:
                begin
                    if (wbyte != 8'h00)
                        n.limit_s = wbyte;
                end
                default:
                begin
                    n.limit_s = n.limit_s;
                end
            endcase
        end

        // register reads, answered in the following cycle
        // clear registers and unmapped indices read zero
        if (reg_rd)
        begin
            case (reg_addr)
                vsm_pkg::ADDR_COIL_MODE: n.rdata = 32'(r.coil_mode);
                vsm_pkg::ADDR_DRIVE_MODE: n.rdata = 32'(r.drive_mode);
                vsm_pkg::ADDR_STROKE_COUNT: n.rdata = r.odo;
                vsm_pkg::ADDR_RECOVERY: n.rdata = 32'(r.recov);
                vsm_pkg::ADDR_LAST_STROKE: n.rdata = r.trans_ms;
                vsm_pkg::ADDR_STROKE_LIMIT: n.rdata = 32'(r.limit_s);
                vsm_pkg::ADDR_SHUT_STATE: n.rdata = 32'(shut_s);
                vsm_pkg::ADDR_TRAVEL_STATE: n.rdata = 32'(travel_s);
                vsm_pkg::ADDR_TIMEOUT_STATE: n.rdata = 32'(r.alarm);
                vsm_pkg::ADDR_EXT_ALARM: n.rdata = 32'(r.ext);
                vsm_pkg::ADDR_ACTION_TIME: n.rdata = r.action_ms;
                default: n.rdata = '0;
            endcase
        end

        // coil drive: single follows the command, dual gated by drive mode
        // halt, or an expired pulse window in pulsed drive, drops both dual coils
        // single coil follows the command in every state
        dual = (r.coil_mode == vsm_pkg::COIL_DUAL);
        energ = (n.st != vsm_pkg::ST_HALT)
            && (r.drive_mode == vsm_pkg::DRIVE_HOLD || n.pulse_on);
        n.coil_open = dual ? (energ && n.cmd_q) : n.cmd_q;
        n.coil_close = dual && energ && !n.cmd_q;

        // readback to output one: open contact in readback mode, else command
        n.readback = (r.coil_mode == vsm_pkg::COIL_READBACK) ? travel_s : n.cmd_q;

        // discrete input channels and external alarm
        // the timeout latch is shown as it will stand next cycle
        n.ext = lk.pins_s[vsm_pkg::PIN_EXT];
        n.in_ch1 = n.alarm;
        n.in_ch2 = n.ext;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // asynchronous clear to the reset image
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            r <= RST;
        else
            r <= n;
    end

    // outputs straight from the state register
    assign reg_rdata = r.rdata;
    assign coil_open_drive = r.coil_open;
    assign coil_close_drive = r.coil_close;
    assign first_output_readback = r.readback;
    assign first_input_channel = r.in_ch1;
    assign second_input_channel = r.in_ch2;
endmodule : vsm_valve_stroke_monitor
`default_nettype wire

//--- tb/vsm_valve_stroke_monitor_sva.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the stroke monitor
module vsm_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [vsm_pkg::AW-1:0] reg_addr,
    input wire logic [vsm_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [vsm_pkg::DW-1:0] reg_rdata,
    input wire logic stroke_cmd_open,
    input wire logic ext_alarm_contact,
    input wire logic coil_open_drive,
    input wire logic coil_close_drive,
    input wire logic first_input_channel,
    input wire logic second_input_channel
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic clr_w;
    // host write that clears the timeout latch
    assign clr_w = reg_wr && reg_addr == vsm_pkg::ADDR_ALARM_CLEAR && reg_wdata[7:0] != 8'h00;
    ////////////////////////////////////////
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data not idle");
    a_unmapped_zero: assert property (reg_rd && reg_addr > vsm_pkg::ADDR_ACTION_TIME
        |=> reg_rdata == '0) else $error("unmapped read not zero");
    a_limit_nonzero: assert property (reg_rd && reg_addr == vsm_pkg::ADDR_STROKE_LIMIT
        |=> reg_rdata != '0) else $error("stroke limit zero");
    a_drive_legal: assert property (reg_rd && reg_addr == vsm_pkg::ADDR_DRIVE_MODE
        |=> reg_rdata inside {32'h1, 32'h2}) else $error("drive setting illegal");
    a_coils_exclusive: assert property (!(coil_open_drive && coil_close_drive))
        else $error("both coils driven");
    a_open_follows: assert property ($rose(stroke_cmd_open)
        |=> coil_open_drive && !coil_close_drive) else $error("open coil late");
    a_close_follows: assert property ($fell(stroke_cmd_open) |=> !coil_open_drive)
        else $error("open coil stays on");
    a_ext_follow: assert property (ext_alarm_contact [*5] |-> second_input_channel)
        else $error("contact not passed on");
    a_alarm_holds: assert property (first_input_channel && !clr_w && !$past(clr_w)
        |=> first_input_channel) else $error("timeout latch dropped");
    a_alarm_clear: assert property (clr_w |-> ##[1:2] !first_input_channel)
        else $error("timeout latch not cleared");
    // main scenarios reached
    c_timeout: cover property ($rose(first_input_channel));
    c_pulse_end: cover property ($fell(coil_open_drive) && stroke_cmd_open);
    c_clear: cover property (clr_w);
endmodule : vsm_chk
bind vsm_valve_stroke_monitor vsm_chk vsm_chk_inst (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stroke_cmd_open(stroke_cmd_open),
    .ext_alarm_contact(ext_alarm_contact), .coil_open_drive(coil_open_drive),
    .coil_close_drive(coil_close_drive), .first_input_channel(first_input_channel),
    .second_input_channel(second_input_channel));
`default_nettype wire

//--- tb/vsm_valve_plant.sv
`timescale 1ns/10ps
`default_nettype none
// valve with pilot coils and two limit switches
module vsm_valve_plant (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic coil_open_drive,
    input wire logic coil_close_drive,
    input wire logic single_coil,
    input wire logic stuck,
    input wire logic [7:0] travel_cycles,
    output logic shut_position_contact,
    output logic travel_position_contact
);
    logic [7:0] pos_r;
    // travel one step a cycle; spring return in single-coil use
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pos_r <= 8'h00;
        else if (!stuck && coil_open_drive && pos_r < travel_cycles)
            pos_r <= pos_r + 8'h01;
        else if (!stuck && (coil_close_drive || (single_coil && !coil_open_drive))
                 && pos_r > 8'h00)
            pos_r <= pos_r - 8'h01;
    end
    // contacts made only at the two ends, open in between
    assign shut_position_contact = pos_r == 8'h00;
    assign travel_position_contact = pos_r >= travel_cycles;
endmodule : vsm_valve_plant
`default_nettype wire

//--- tb/test_vsm_valve_stroke_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module test_vsm_valve_stroke_monitor;
    localparam int TK = 4; // cycles per ms tick
    localparam int LIM = 1000 * TK; // one-second limit in cycles
    logic clk, arst_n, reg_wr, reg_rd, cmd, ext, stuck, single, rd_d;
    logic sh, tr, co, cc, rb, fic, sic;
    logic [vsm_pkg::AW-1:0] addr;
    logic [31:0] wdata, rdata;
    logic [7:0] trv;
    logic [31:0] lo_q[$];
    logic [31:0] hi_q[$];
    integer seed;
    int failures, total_checks;
    vsm_valve_stroke_monitor #(.TICK_CYCLES(TK)) vsm_valve_stroke_monitor_inst (.clk(clk),
        .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .stroke_cmd_open(cmd), .shut_position_contact(sh),
        .travel_position_contact(tr), .ext_alarm_contact(ext), .coil_open_drive(co),
        .coil_close_drive(cc), .first_output_readback(rb), .first_input_channel(fic),
        .second_input_channel(sic));
    vsm_valve_plant vsm_valve_plant_inst (.clk(clk), .arst_n(arst_n), .coil_open_drive(co),
        .coil_close_drive(cc), .single_coil(single), .stuck(stuck), .travel_cycles(trv),
        .shut_position_contact(sh), .travel_position_contact(tr));
    ////////////////////////////////////////
    // clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task report_and_stop;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [31:0] lo, input logic [31:0] hi,
             input logic [31:0] seen);
        total_checks++;
        if (!((seen >= lo) === 1'b1 && (seen <= hi) === 1'b1))
        begin
            failures++;
            $display("MISMATCH %s expected %0h..%0h seen %0h", nm, lo, hi, seen);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task wr(input logic [vsm_pkg::AW-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read request; the expected range waits in the queues
    task rd(input logic [vsm_pkg::AW-1:0] a, input logic [31:0] lo, input logic [31:0] hi);
        lo_q.push_back(lo);
        hi_q.push_back(hi);
        @(posedge clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    // bounded wait for the valve to reach one end
    task wait_end(input logic op);
        int i;
        i = 0;
        while (((op ? tr : sh) !== 1'b1) && i < 500)
        begin
            @(posedge clk);
            i++;
        end
        if (i == 500)
        begin
            failures++;
            report_and_stop();
        end
    endtask : wait_end
    // read data watcher: compare against the oldest expectation
    always @(posedge clk)
    begin
        rd_d <= reg_rd;
        if (rd_d === 1'b1)
            chk("read data", lo_q.pop_front(), hi_q.pop_front(), rdata);
    end
    ////////////////////////////////////////
    initial
    begin
        seed = 32'h09F1;
        {arst_n, reg_wr, reg_rd, cmd, ext, stuck, single} = 7'h00;
        addr = '0;
        wdata = 32'h0;
        trv = 8'h14 + 8'({$random(seed)} % 40);
        cyc(3);
        arst_n <= 1'b1;
        cyc(2);
        wr(vsm_pkg::ADDR_COIL_MODE, 32'h3);
        wr(6'h3F, 32'h5);
        rd(vsm_pkg::ADDR_COIL_MODE, 32'h2, 32'h2);
        rd(vsm_pkg::ADDR_DRIVE_MODE, 32'h2, 32'h2);
        rd(vsm_pkg::ADDR_RECOVERY, 32'h1, 32'h1);
        rd(vsm_pkg::ADDR_STROKE_LIMIT, 32'hA, 32'hA);
        rd(6'h3F, 32'h0, 32'h0);
        wr(vsm_pkg::ADDR_STROKE_LIMIT, 32'h1);
        // open stroke, then hold drive past the limit
        cmd <= 1'b1;
        wait_end(1'b1);
        cyc(4);
        rd(vsm_pkg::ADDR_TRAVEL_STATE, 32'h1, 32'h1);
        rd(vsm_pkg::ADDR_SHUT_STATE, 32'h0, 32'h0);
        rd(vsm_pkg::ADDR_STROKE_COUNT, 32'h1, 32'h1);
        rd(vsm_pkg::ADDR_LAST_STROKE, trv / TK - 1, trv / TK + 3);
        cyc(LIM);
        chk("open coil", 32'h1, 32'h1, {31'h0, co});
        chk("timeout", 32'h0, 32'h0, {31'h0, fic});
        rd(vsm_pkg::ADDR_ACTION_TIME, LIM / TK, LIM / TK + 40);
        // close stroke, counter clear
        cmd <= 1'b0;
        wait_end(1'b0);
        cyc(4);
        rd(vsm_pkg::ADDR_STROKE_COUNT, 32'h2, 32'h2);
        wr(vsm_pkg::ADDR_COUNT_CLEAR, 32'h1);
        rd(vsm_pkg::ADDR_STROKE_COUNT, 32'h0, 32'h0);
        // pulsed drive lasts one limit period
        wr(vsm_pkg::ADDR_DRIVE_MODE, 32'h1);
        cmd <= 1'b1;
        cyc(LIM - 20);
        chk("pulse on", 32'h1, 32'h1, {31'h0, co});
        cyc(40);
        chk("pulse off", 32'h0, 32'h0, {31'h0, co});
        // stuck valve times out, recovery retries
        wr(vsm_pkg::ADDR_DRIVE_MODE, 32'h2);
        stuck <= 1'b1;
        cmd <= 1'b0;
        cyc(LIM - 20);
        chk("timeout early", 32'h0, 32'h0, {31'h0, fic});
        cyc(40);
        chk("timeout", 32'h1, 32'h1, {31'h0, fic});
        chk("retry coil", 32'h1, 32'h1, {31'h0, cc});
        rd(vsm_pkg::ADDR_ACTION_TIME, 32'h0, 32'hA);
        rd(vsm_pkg::ADDR_TIMEOUT_STATE, 32'h1, 32'h1);
        wr(vsm_pkg::ADDR_ALARM_CLEAR, 32'h1);
        rd(vsm_pkg::ADDR_TIMEOUT_STATE, 32'h0, 32'h0);
        // waiting recovery halts until the command changes
        wr(vsm_pkg::ADDR_RECOVERY, 32'h2);
        cmd <= 1'b1;
        cyc(10);
        cmd <= 1'b0;
        cyc(LIM + 20);
        chk("halt", 32'h0, 32'h0, {30'h0, co, cc});
        chk("timeout pin", 32'h1, 32'h1, {31'h0, fic});
        stuck <= 1'b0;
        cyc(50);
        chk("still halted", 32'h0, 32'h0, {31'h0, cc});
        cmd <= 1'b1;
        cyc(3);
        chk("new command", 32'h1, 32'h1, {31'h0, co});
        // single coil and readback
        single <= 1'b1;
        wr(vsm_pkg::ADDR_COIL_MODE, 32'h1);
        cmd <= 1'b0;
        cyc(3);
        chk("single coils", 32'h0, 32'h0, {30'h0, co, cc});
        wait_end(1'b0);
        wr(vsm_pkg::ADDR_COIL_MODE, 32'h3);
        rd(vsm_pkg::ADDR_COIL_MODE, 32'h3, 32'h3);
        chk("readback shut", 32'h0, 32'h0, {31'h0, rb});
        cmd <= 1'b1;
        cyc(3);
        chk("readback moving", 32'h0, 32'h0, {31'h0, rb});
        wait_end(1'b1);
        cyc(4);
        chk("readback open", 32'h1, 32'h1, {31'h0, rb});
        // dry contact passed on
        for (int k = 0; k < 4; k++)
        begin
            ext <= 1'($random(seed));
            cyc(6);
            chk("contact pin", {31'h0, ext}, {31'h0, ext}, {31'h0, sic});
            rd(vsm_pkg::ADDR_EXT_ALARM, {31'h0, ext}, {31'h0, ext});
        end
        cyc(3);
        report_and_stop();
    end
endmodule : test_vsm_valve_stroke_monitor
`default_nettype wire
